// File: logic/rlo_pkg.sv
// Constants and types for the right line-output mix and power status slice.
// Assumes a byte-wide register port driven by the codec's control bus logic.
//
// What this block does
// - Mix bit D7 routes source to output
// - Mix bits D6-D0 hold 7-bit volume code
// - Level D7-D4 sets 0 to 9 dB
// - Level D3 clear mutes, set unmutes
// - Level D1 reads 1 while gains pending
// - Output power-up shown in two places
// - Status D7/D6 show left/right DAC power
// - Status D4 shows left line output power
// - Status D2/D1 show headphone driver power
package rlo_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_LINE2_MIX = 8'h5a;
  localparam logic [7:0] OFF_GAIN_AMP_MIX = 8'h5b;
  localparam logic [7:0] OFF_DAC_MIX = 8'h5c;
  localparam logic [7:0] OFF_LEVEL = 8'h5d;
  localparam logic [7:0] OFF_POWER = 8'h5e;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int MIX_ROUTE_BIT = 7;
  localparam int LVL_MUTE_BIT = 3;
  localparam int LVL_PEND_BIT = 1;
  localparam int LVL_PWR_BIT = 0;
  localparam int PWR_LDAC_BIT = 7;
  localparam int PWR_RDAC_BIT = 6;
  localparam int PWR_LLO_BIT = 4;
  localparam int PWR_RLO_BIT = 3;
  localparam int PWR_LHP_BIT = 2;
  localparam int PWR_RHP_BIT = 1;
  localparam logic [7:0] MIX_RESET = 8'h00;
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [3:0] LEVEL_MAX = 4'h9;
  localparam logic PEND_RESET = 1'b1;
  localparam int NUM_MIX = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic route;
    logic [6:0] volume;
  } rlo_mix_t;

  typedef struct packed {
    logic left_dac;
    logic right_dac;
    logic left_line_output;
    logic right_line_output;
    logic left_headphone_driver;
    logic right_headphone_driver;
  } rlo_power_t;

endpackage : rlo_pkg

// File: logic/rlo_mix_reg.sv
// One read/write mix register: route bit and volume code.
// Assumes write strobe is a one-cycle pulse in the clock domain.
module rlo_mix_reg (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Stored value
  output rlo_pkg::rlo_mix_t mix
);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mix <= rlo_pkg::MIX_RESET;
    end else if (wr_en) begin
      mix.route <= wr_data[rlo_pkg::MIX_ROUTE_BIT];
      mix.volume <= wr_data[6:0];
    end
  end

endmodule : rlo_mix_reg

// File: logic/rlo_regs.sv
// Right line-output mix and power status register slice: three mix
// registers, the output level register and the module power status word.
// Assumes the codec core supplies power and gain-ramp status synchronously
// to clock, and that software never raises the read and write strobes in
// the same cycle.
module rlo_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Status from the codec core
  input wire rlo_pkg::rlo_power_t power_in,
  input wire logic gain_pending_in,
  // Controls to the analog path
  output rlo_pkg::rlo_mix_t line2_mix,
  output rlo_pkg::rlo_mix_t gain_amp_mix,
  output rlo_pkg::rlo_mix_t dac_mix,
  output logic [3:0] out_level,
  output logic out_unmute
);

  // ----------------------------------------
  // Mix registers
  // ----------------------------------------
  logic [7:0] mix_off [rlo_pkg::NUM_MIX];
  rlo_pkg::rlo_mix_t mix_q [rlo_pkg::NUM_MIX];

  assign mix_off[0] = rlo_pkg::OFF_LINE2_MIX;
  assign mix_off[1] = rlo_pkg::OFF_GAIN_AMP_MIX;
  assign mix_off[2] = rlo_pkg::OFF_DAC_MIX;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // One strobe per writable register; the status offset has none, so
  // writes to it fall away here
  logic mix_wr [rlo_pkg::NUM_MIX];
  logic level_wr;

  always_comb begin
    level_wr = 1'b0;
    if (reg_wr && (reg_addr == rlo_pkg::OFF_LEVEL)) begin
      level_wr = 1'b1;
    end
  end

  // ----------------------------------------
  // Mix register instances
  // ----------------------------------------
  // Route bit and volume code per source, one instance each
  genvar gi;
  generate
    for (gi = 0; gi < rlo_pkg::NUM_MIX; gi++) begin : g_mix
      assign mix_wr[gi] = reg_wr && (reg_addr == mix_off[gi]);
      rlo_mix_reg u_mix (
        .clock(clock),
        .rst_b(rst_b),
        .wr_en(mix_wr[gi]),
        .wr_data(reg_wdata),
        .mix(mix_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign line2_mix = mix_q[0];
  assign gain_amp_mix = mix_q[1];
  assign dac_mix = mix_q[2];

  // ----------------------------------------
  // Level register writable fields
  // ----------------------------------------
  // Codes above the 9 dB step are stored as written
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_level <= rlo_pkg::LEVEL_RESET;
    end else if (level_wr) begin
      out_level <= reg_wdata[7:4];
    end
  end

  // Output starts muted out of reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_unmute <= 1'b0;
    end else if (level_wr) begin
      out_unmute <= reg_wdata[rlo_pkg::LVL_MUTE_BIT];
    end
  end

  // ----------------------------------------
  // Status capture
  // ----------------------------------------
  // Each status bit is one flop behind the core, refreshed every cycle
  logic pend_reg;
  logic [1:0] dac_pwr_reg;
  logic [1:0] line_pwr_reg;
  logic [1:0] hp_pwr_reg;

  // Gain ramp status; reads pending out of reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= rlo_pkg::PEND_RESET;
    end else begin
      pend_reg <= gain_pending_in;
    end
  end

  // DAC power status, left side in the upper bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dac_pwr_reg <= 2'h0;
    end else begin
      dac_pwr_reg <= {power_in.left_dac, power_in.right_dac};
    end
  end

  // Line output power status, left side in the upper bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      line_pwr_reg <= 2'h0;
    end else begin
      line_pwr_reg <= {power_in.left_line_output,
        power_in.right_line_output};
    end
  end

  // Headphone driver power status, left side in the upper bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hp_pwr_reg <= 2'h0;
    end else begin
      hp_pwr_reg <= {power_in.left_headphone_driver,
        power_in.right_headphone_driver};
    end
  end

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  logic [7:0] level_rd_val;
  logic [7:0] power_rd_val;

  // Level register image; bit 2 is reserved and stays zero
  always_comb begin
    level_rd_val = 8'h00;
    level_rd_val[7:4] = out_level;
    level_rd_val[rlo_pkg::LVL_MUTE_BIT] = out_unmute;
    level_rd_val[rlo_pkg::LVL_PEND_BIT] = pend_reg;
    level_rd_val[rlo_pkg::LVL_PWR_BIT] = line_pwr_reg[0];
  end

  // Power status image; bits 5 and 0 are reserved and stay zero
  always_comb begin
    power_rd_val = 8'h00;
    power_rd_val[rlo_pkg::PWR_LDAC_BIT] = dac_pwr_reg[1];
    power_rd_val[rlo_pkg::PWR_RDAC_BIT] = dac_pwr_reg[0];
    power_rd_val[rlo_pkg::PWR_LLO_BIT] = line_pwr_reg[1];
    power_rd_val[rlo_pkg::PWR_RLO_BIT] = line_pwr_reg[0];
    power_rd_val[rlo_pkg::PWR_LHP_BIT] = hp_pwr_reg[1];
    power_rd_val[rlo_pkg::PWR_RHP_BIT] = hp_pwr_reg[0];
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic hit_next;

  always_comb begin
    case (reg_addr)
      rlo_pkg::OFF_LINE2_MIX,
      rlo_pkg::OFF_GAIN_AMP_MIX,
      rlo_pkg::OFF_DAC_MIX,
      rlo_pkg::OFF_LEVEL,
      rlo_pkg::OFF_POWER: hit_next = 1'b1;
      default: hit_next = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped offsets read as zero
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      rlo_pkg::OFF_LINE2_MIX: rdata_next = mix_q[0];
      rlo_pkg::OFF_GAIN_AMP_MIX: rdata_next = mix_q[1];
      rlo_pkg::OFF_DAC_MIX: rdata_next = mix_q[2];
      rlo_pkg::OFF_LEVEL: rdata_next = level_rd_val;
      rlo_pkg::OFF_POWER: rdata_next = power_rd_val;
      default: rdata_next = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Answer flops
  // ----------------------------------------
  // Reads are side-effect free; data is zero outside a read answer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Acknowledge for any access to a mapped offset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_hit <= 1'b0;
    end else begin
      reg_hit <= (reg_rd || reg_wr) && hit_next;
    end
  end

endmodule : rlo_regs

// File: test/rlo_regs_sva.sv
// Assertions on the ports of the right line-out register slice.
// Assumes binding into rlo_regs; status inputs pass one flop.
module rlo_regs_chk (
  // Clock and reset
  input logic clock,
  input logic rst_b,
  // Register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic reg_hit,
  // Status and controls
  input rlo_pkg::rlo_power_t power_in,
  input logic gain_pending_in,
  input rlo_pkg::rlo_mix_t line2_mix,
  input rlo_pkg::rlo_mix_t gain_amp_mix,
  input rlo_pkg::rlo_mix_t dac_mix,
  input logic [3:0] out_level,
  input logic out_unmute
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_MIX_A:
  assert property (reg_wr && reg_addr == 8'h5a |=>
    line2_mix == $past(reg_wdata)) else $error("line2 mix");
  AST_MIX_B:
  assert property (reg_wr && reg_addr == 8'h5b |=>
    gain_amp_mix == $past(reg_wdata)) else $error("gain amp mix");
  AST_MIX_C:
  assert property (reg_wr && reg_addr == 8'h5c |=>
    dac_mix == $past(reg_wdata)) else $error("dac mix");
  AST_LEVEL:
  assert property (reg_wr && reg_addr == 8'h5d |=>
    {out_level, out_unmute} == $past(reg_wdata[7:3])) else $error("level");
  AST_LVL_RD:
  assert property (reg_rd && reg_addr == 8'h5d |=> reg_rdata[2:0] ==
    {1'b0, $past(gain_pending_in, 2), $past(power_in.right_line_output, 2)})
    else $error("level status");
  AST_PWR_RD:
  assert property (reg_rd && reg_addr == 8'h5e |=> reg_rdata ==
    {$past(power_in[5:4], 2), 1'b0, $past(power_in[3:0], 2), 1'b0})
    else $error("power status");
  AST_HOLD:
  assert property (!reg_wr || reg_addr == 8'h5e |=> $stable({line2_mix,
    gain_amp_mix, dac_mix, out_level, out_unmute})) else $error("hold");
  AST_UNMAPPED:
  assert property ((reg_wr || reg_rd) && reg_addr > 8'h5e |=>
    !reg_hit && reg_rdata == 8'h00) else $error("unmapped");
endmodule : rlo_regs_chk

bind rlo_regs rlo_regs_chk chk_u (.*);

// File: test/rlo_regs_tb_top.sv
// Directed bench for the right line-out register slice.
// Assumes one-cycle strobes and registered read data.
module rlo_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_hit;
  logic gain_pending_in = 1, out_unmute;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [3:0] out_level;
  rlo_pkg::rlo_power_t power_in = '0;
  rlo_pkg::rlo_mix_t line2_mix, gain_amp_mix, dac_mix;
  int fail_count = 0, n_checks = 0;
  rlo_regs dut_u (.*);
  always #4 clock = ~clock;
  task chk(string n, logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr(logic [7:0] a, d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock) #1 reg_wr = 0;
    @(posedge clock) #1;
  endtask : wr
  task rd(logic [7:0] a, e);
    reg_rd = 1;
    reg_addr = a;
    @(posedge clock) #1 reg_rd = 0;
    chk("rdata", reg_rdata, e);
    chk("hit", reg_hit, a >= 8'h5a && a <= 8'h5e);
    @(posedge clock) #1;
  endtask : rd
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(posedge clock);
    #1 rst_b = 1;
    for (int i = 0; i < 3; i++) rd(8'(8'h5a + i), 8'h00);
    rd(8'h5d, 8'h02);
    rd(8'h5e, 8'h00);
    for (int i = 0; i < 3; i++) wr(8'(8'h5a + i), 8'(8'h80 >> i) ^ 8'h7f);
    chk("line2_mix", line2_mix, 8'hff);
    chk("gain_amp_mix", gain_amp_mix, 8'h3f);
    chk("dac_mix", dac_mix, 8'h5f);
    for (int i = 0; i < 3; i++)
      rd(8'(8'h5a + i), 8'(8'h80 >> i) ^ 8'h7f);
    for (int c = 0; c < 10; c++) begin
      wr(8'h5d, {4'(c), 4'hb});
      rd(8'h5d, {4'(c), 4'ha});
      chk("out_level", {4'h0, out_level}, 8'(c));
    end
    wr(8'h5d, 8'h90);
    chk("unmute", out_unmute, 0);
    chk("out_level", {4'h0, out_level}, 8'h09);
    for (int k = 0; k < 6; k++) begin
      power_in = 6'(1 << k);
      gain_pending_in = k[0];
      @(posedge clock) #1;
      wr(8'h5e, 8'hde);
      rd(8'h5e, {power_in[5:4], 1'b0, power_in[3:0], 1'b0});
      rd(8'h5d, {6'h24, gain_pending_in, power_in[2]});
    end
    rd(8'h5f, 8'h00);
    rst_b = 0;
    @(posedge clock) #1 rst_b = 1;
    chk("out_level", {4'h0, out_level}, 8'h00);
    chk("out_unmute", {7'h00, out_unmute}, 8'h00);
    chk("dac_mix", dac_mix, 8'h00);
    rd(8'h5a, 8'h00);
    rd(8'h5d, 8'h02);
    end_of_test;
  end
endmodule : rlo_regs_tb_top
